/* test/fault_status_registers_bench.sv */
// Purpose: self-checking bench for the supply and boost fault flag registers
// Assumes: detectors are held as levels by the bench, one core clock
// Notes:   the bench models stored clear controls and sticky flags itself
module fault_status_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                       i_core_clk;
  logic                       i_rst;
  logic [fsr_pkg::ADDR_W-1:0] i_addr;
  logic [fsr_pkg::DATA_W-1:0] i_wdata;
  logic                       i_wr;
  logic                       i_rd;
  logic [fsr_pkg::N_FLT-1:0]  i_fault_det;
  logic [fsr_pkg::DATA_W-1:0] o_rdata;
  logic                       o_fault_irq;
  int                         mismatches;
  int                         checked;
  int                         cycles;
  logic [15:0]                sup_exp;
  logic [15:0]                bst_exp;
  logic [15:0]                d;

  fsr_fault_regs dut (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_addr      (i_addr),
    .i_wdata     (i_wdata),
    .i_wr        (i_wr),
    .i_rd        (i_rd),
    .i_fault_det (i_fault_det),
    .o_rdata     (o_rdata),
    .o_fault_irq (o_fault_irq)
  );

  // free-running core clock, 10 ns period
  initial i_core_clk = 1'b0;
  always #5 i_core_clk = ~i_core_clk;

  // hang guard; the whole run needs well under a thousand cycles
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle write; the model keeps clear controls, flag bits are never set by writes
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
    if (a == fsr_pkg::SUPPLY_ADDR)
      sup_exp = (sup_exp & 16'h0AAA) | (v & 16'h0555);
    else if (a == fsr_pkg::BOOST_ADDR)
      bst_exp = (bst_exp & 16'hAAAA) | (v & 16'h5555);
  endtask

  // data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  // raise detectors, wait out the synchroniser and pin latency, then drop all but those in keep
  task automatic pulse(input logic [13:0] m, input logic [13:0] keep);
    @(posedge i_core_clk);
    i_fault_det <= m;
    repeat (6) @(posedge i_core_clk);
    i_fault_det <= keep;
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask

  task automatic t_reset();
    rd(fsr_pkg::SUPPLY_ADDR, d);
    chk(d, 16'h0000);
    rd(fsr_pkg::BOOST_ADDR, d);
    chk(d, 16'h0000);
    chk({15'h0000, o_fault_irq}, 16'h0000);
  endtask

  // every fault: position, half-pair writes, full clear, pin release
  task automatic t_each_fault();
    logic [7:0]  a;
    logic [15:0] f;
    for (int k = 0; k < 14; k++)
    begin
      a = (k < 6) ? fsr_pkg::SUPPLY_ADDR : fsr_pkg::BOOST_ADDR;
      f = 16'h0002 << (2 * ((k < 6) ? k : k - 6));
      pulse(14'h0001 << k, 14'h0000);
      if (k < 6)
        sup_exp = sup_exp | f;
      else
        bst_exp = bst_exp | f;
      chk({15'h0000, o_fault_irq}, {15'h0000, k != 6});
      rd(a, d);
      chk(d, (k < 6) ? sup_exp : bst_exp);
      wr(a, f);
      wr(a, f >> 1);
      rd(a, d);
      chk(d, (k < 6) ? sup_exp : bst_exp);
      chk({15'h0000, o_fault_irq}, {15'h0000, k != 6});
      wr(a, f | (f >> 1));
      if (k < 6)
        sup_exp = sup_exp & ~f;
      else
        bst_exp = bst_exp & ~f;
      rd(a, d);
      chk(d, (k < 6) ? sup_exp : bst_exp);
      chk({15'h0000, o_fault_irq}, 16'h0000);
      wr(a, 16'h0000);
    end
  endtask

  // pin stays up while another latch is pending; a held detector beats the clear
  task automatic t_shared_pin();
    pulse(14'h2001, 14'h2000);
    sup_exp = sup_exp | 16'h0002;
    bst_exp = bst_exp | 16'h8000;
    wr(fsr_pkg::SUPPLY_ADDR, 16'h0003);
    sup_exp = sup_exp & 16'hFFFD;
    rd(fsr_pkg::SUPPLY_ADDR, d);
    chk(d, sup_exp);
    chk({15'h0000, o_fault_irq}, 16'h0001);
    wr(fsr_pkg::BOOST_ADDR, 16'hC000);
    rd(fsr_pkg::BOOST_ADDR, d);
    chk(d, bst_exp);
    chk({15'h0000, o_fault_irq}, 16'h0001);
    pulse(14'h0000, 14'h0000);
    wr(fsr_pkg::BOOST_ADDR, 16'hC000);
    bst_exp = bst_exp & 16'h7FFF;
    rd(fsr_pkg::BOOST_ADDR, d);
    chk(d, bst_exp);
    chk({15'h0000, o_fault_irq}, 16'h0000);
    @(posedge i_core_clk);
    #1;
    chk(o_rdata, 16'h0000);
  endtask

  // a full supply write clears every pair; unmapped writes change nothing, unmapped reads give zero
  task automatic t_refused();
    pulse(14'h0020, 14'h0000);
    chk({15'h0000, o_fault_irq}, 16'h0001);
    wr(fsr_pkg::SUPPLY_ADDR, 16'h0FFF);
    sup_exp = sup_exp & 16'h0555;
    rd(fsr_pkg::SUPPLY_ADDR, d);
    chk(d, sup_exp);
    chk({15'h0000, o_fault_irq}, 16'h0000);
    wr(8'h11, 16'hFFFF);
    wr(fsr_pkg::SUPPLY_ADDR, 16'hF000);
    rd(fsr_pkg::SUPPLY_ADDR, d);
    chk(d, sup_exp);
    rd(fsr_pkg::BOOST_ADDR, d);
    chk(d, bst_exp);
    rd(8'h11, d);
    chk(d, 16'h0000);
  endtask

  // a second reset in mid-run drops flags and the pin
  task automatic t_midreset();
    pulse(14'h0080, 14'h0000);
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    sup_exp = 16'h0000;
    bst_exp = 16'h0000;
    rd(fsr_pkg::BOOST_ADDR, d);
    chk(d, 16'h0000);
    chk({15'h0000, o_fault_irq}, 16'h0000);
  endtask

  // reset for two cycles, then run every scenario in turn
  initial
  begin
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_fault_det = 14'h0000;
    mismatches = 0;
    checked = 0;
    cycles = 0;
    sup_exp = 16'h0000;
    bst_exp = 16'h0000;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    t_reset();
    t_each_fault();
    t_shared_pin();
    t_refused();
    t_midreset();
    conclude();
  end
endmodule

/* verilog/fsr_fault_regs.sv */
// Purpose: supply and boost fault status registers with paired clearing
// Assumes: fault detectors are asynchronous levels or pulses
// Notes:   read data appears the cycle after the read strobe only

// Functional notes
// - a write with a fault's flag bit and clear bit both 1 clears that flag and its interrupt pin share, unless the synchronised fault sets it in the same cycle.
// - the supply register holds the charge pump fault clear control at bit 10.
// - supply bit 9 flags a missing pump capacitor, with its clear control at bit 8.
// - supply bit 7 flags input over-current, with its clear control at bit 6.
// - supply bit 5 flags logic supply under-voltage, with its clear control at bit 4.
// - supply bit 3 flags input over-voltage, with its clear control at bit 2.
// - supply bit 1 flags input under-voltage, with its clear control at bit 0.
// - the boost register at 10h flags thermal trip at bit 15 with its clear control at bit 14.
// - boost bit 13 flags a shorted current resistor, with its clear control at bit 12.
// - boost bit 11 flags a missing string resistor, with its clear control at bit 10.
// - boost bit 9 flags a missing mode resistor, with its clear control at bit 8.
// - boost bit 7 flags a missing frequency resistor, with its clear control at bit 6.
// - boost bit 5 flags converter over-current, with its clear control at bit 4.
// - boost bit 3 flags converter high over-voltage, with its clear control at bit 2.
// - boost bit 1 flags converter low over-voltage, clear at bit 0, and it never drives the pin.
module fsr_fault_regs (
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst,
  input  wire logic [fsr_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [fsr_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  input  wire logic [fsr_pkg::N_FLT-1:0]    i_fault_det,
  output logic      [fsr_pkg::DATA_W-1:0]   o_rdata,
  output logic                              o_fault_irq
);
  typedef struct packed {
    logic [fsr_pkg::N_FLT-1:0]  sync1;
    logic [fsr_pkg::N_FLT-1:0]  sync2;
    logic [fsr_pkg::N_SUP-1:0]  sup_clr;
    logic [fsr_pkg::N_BST-1:0]  bst_clr;
    logic [fsr_pkg::DATA_W-1:0] rdata;
    logic                       irq;
  } fsr_regs_s;

  fsr_regs_s q;
  fsr_regs_s d;

  logic                      wr_sup;
  logic                      wr_bst;
  logic [fsr_pkg::N_BST-1:0] sup_req;
  logic [fsr_pkg::N_BST-1:0] bst_req;
  logic [fsr_pkg::N_BST-1:0] clr_w;

  fsr_flag_if flags ();

  // address match, shared by the write and read decode
  function automatic logic addr_hit(
    input logic [fsr_pkg::ADDR_W-1:0] a,
    input logic [fsr_pkg::ADDR_W-1:0] t
  );
    addr_hit = (a == t);
  endfunction

  // one bit per pair: flag bit and clear bit both written as 1
  function automatic logic [fsr_pkg::N_BST-1:0] pair_req(
    input logic [fsr_pkg::DATA_W-1:0] w
  );
    logic [fsr_pkg::N_BST-1:0] r;
    r = '0;
    for (int k = 0; k < fsr_pkg::N_BST; k++)
    begin
      r[k] = w[fsr_pkg::PAIR_W*k + fsr_pkg::FLAG_OFS] & w[fsr_pkg::PAIR_W*k];
    end
    return r;
  endfunction

  // the clear-control bits as written, kept for read-back
  function automatic logic [fsr_pkg::N_BST-1:0] clr_bits(
    input logic [fsr_pkg::DATA_W-1:0] w
  );
    logic [fsr_pkg::N_BST-1:0] r;
    r = '0;
    for (int k = 0; k < fsr_pkg::N_BST; k++)
    begin
      r[k] = w[fsr_pkg::PAIR_W*k];
    end
    return r;
  endfunction

  // interleave flags and clear controls into the register image
  function automatic logic [fsr_pkg::DATA_W-1:0] pack_reg(
    input logic [fsr_pkg::N_BST-1:0] f,
    input logic [fsr_pkg::N_BST-1:0] c,
    input int unsigned               n
  );
    logic [fsr_pkg::DATA_W-1:0] r;
    r = fsr_pkg::REG_RESET;
    for (int k = 0; k < fsr_pkg::N_BST; k++)
    begin
      if (k < n)
      begin
        r[fsr_pkg::PAIR_W*k + fsr_pkg::FLAG_OFS] = f[k];
        r[fsr_pkg::PAIR_W*k]                     = c[k];
      end
    end
    return r;
  endfunction

  // write decode; flags themselves are never set by software
  always_comb
  begin
    wr_sup  = i_wr && addr_hit(i_addr, fsr_pkg::SUPPLY_ADDR);
    wr_bst  = i_wr && addr_hit(i_addr, fsr_pkg::BOOST_ADDR);
    sup_req = pair_req(i_wdata);
    bst_req = pair_req(i_wdata);
    clr_w   = clr_bits(i_wdata);
  end

  // clear requests only for the pairs written as 1 and 1
  assign flags.clr = {bst_req & {fsr_pkg::N_BST{wr_bst}},
                      sup_req[fsr_pkg::N_SUP-1:0] & {fsr_pkg::N_SUP{wr_sup}}};
  assign flags.set = q.sync2;

  // next state: synchroniser, clear controls, read data, pin level
  always_comb
  begin
    d       = q;
    d.sync1 = i_fault_det;
    d.sync2 = q.sync1;
    d.rdata = fsr_pkg::REG_RESET;
    if (wr_sup)
    begin
      d.sup_clr = clr_w[fsr_pkg::N_SUP-1:0];
    end
    if (wr_bst)
    begin
      d.bst_clr = clr_w;
    end
    // unmapped reads return zero, upper supply bits read zero
    if (i_rd && addr_hit(i_addr, fsr_pkg::SUPPLY_ADDR))
    begin
      d.rdata = pack_reg({2'h0, flags.flag[fsr_pkg::N_SUP-1:0]},
                         {2'h0, q.sup_clr}, fsr_pkg::N_SUP);
    end
    else if (i_rd && addr_hit(i_addr, fsr_pkg::BOOST_ADDR))
    begin
      d.rdata = pack_reg(flags.flag[fsr_pkg::N_FLT-1:fsr_pkg::N_SUP],
                         q.bst_clr, fsr_pkg::N_BST);
    end
    // pin follows the latches one cycle late so the output is a flop
    d.irq = |flags.pin;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  fsr_flag_bank u_bank (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .bus        (flags.bank)
  );

  assign o_rdata     = q.rdata;
  assign o_fault_irq = q.irq;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // paired write clears the charge pump fault
  AST_PUMP_CLEAR: assert property (
    wr_sup && i_wdata[fsr_pkg::PUMP_CLR_BIT] && i_wdata[fsr_pkg::PUMP_CLR_BIT+1]
    && !q.sync2[fsr_pkg::FI_PUMP] |=> !flags.flag[fsr_pkg::FI_PUMP])
    else $error("pump fault not cleared");

  // paired write releases the pin two cycles later if nothing else is pending
  AST_PIN_RELEASE: assert property (
    wr_sup && (i_wdata == 16'h0FFF) && (q.sync2 == '0) && (q.sync1 == '0)
    && ((flags.pin & 14'h3FC0) == '0) |=> ##1 !o_fault_irq)
    else $error("pin not released");

  // half a pair leaves the flag alone
  AST_HALF_PAIR: assert property (
    wr_sup && i_wdata[fsr_pkg::UV_FLAG_BIT] && !i_wdata[fsr_pkg::UV_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_IN_UV]
    |=> flags.flag[fsr_pkg::FI_IN_UV] == $past(flags.flag[fsr_pkg::FI_IN_UV]))
    else $error("half pair changed flag");

  // a detected fault shows as a register flag after the synchroniser
  AST_SET_LATENCY: assert property (
    i_fault_det[fsr_pkg::FI_CAP] ##1 i_fault_det[fsr_pkg::FI_CAP]
    |=> ##1 flags.flag[fsr_pkg::FI_CAP])
    else $error("capacitor fault not latched");

  // supply read image carries each flag at its position
  AST_SUP_READ: assert property (
    i_rd && addr_hit(i_addr, fsr_pkg::SUPPLY_ADDR)
    |=> o_rdata[fsr_pkg::OC_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_IN_OC])
     && o_rdata[fsr_pkg::LUV_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_LOGIC_UV])
     && o_rdata[fsr_pkg::OV_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_IN_OV])
     && o_rdata[fsr_pkg::CAP_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_CAP]))
    else $error("supply read mismatch");

  AST_SUP_UV_READ: assert property (
    i_rd && addr_hit(i_addr, fsr_pkg::SUPPLY_ADDR)
    |=> o_rdata[fsr_pkg::UV_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_IN_UV]))
    else $error("under-voltage read mismatch");

  // boost read image carries each flag at its position
  AST_BST_READ: assert property (
    i_rd && addr_hit(i_addr, fsr_pkg::BOOST_ADDR)
    |=> o_rdata[fsr_pkg::THERM_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_THERMAL])
     && o_rdata[fsr_pkg::CURR_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_CURRENT])
     && o_rdata[fsr_pkg::STR_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_STRING])
     && o_rdata[fsr_pkg::MODE_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_MODE]))
    else $error("boost read mismatch");

  AST_BST_LOW_READ: assert property (
    i_rd && addr_hit(i_addr, fsr_pkg::BOOST_ADDR)
    |=> o_rdata[fsr_pkg::FREQ_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_FREQ])
     && o_rdata[fsr_pkg::COC_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_CONV_OC])
     && o_rdata[fsr_pkg::HOVP_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_HIGH_OVP])
     && o_rdata[fsr_pkg::LOVP_FLAG_BIT] == $past(flags.flag[fsr_pkg::FI_LOW_OVP]))
    else $error("boost low read mismatch");

  // low ovp clears from the register but has no pin share
  AST_LOWOVP_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::LOVP_FLAG_BIT] && i_wdata[fsr_pkg::LOVP_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_LOW_OVP] |=> !flags.flag[fsr_pkg::FI_LOW_OVP]
    && !flags.pin[fsr_pkg::FI_LOW_OVP])
    else $error("low ovp clear failed");

  // read data stands only in the cycle after the strobe
  AST_RDATA_ONLY: assert property (
    !i_rd |=> o_rdata == fsr_pkg::REG_RESET)
    else $error("read data without strobe");

  // thermal fault survives a clear in the cycle it is detected
  AST_THERM_SET_WINS: assert property (
    wr_bst && q.sync2[fsr_pkg::FI_THERMAL] |=> flags.flag[fsr_pkg::FI_THERMAL])
    else $error("thermal fault lost");

  // a pending string resistor pin latch raises the output one cycle later
  AST_IRQ_FOLLOWS: assert property (
    flags.pin[fsr_pkg::FI_STRING] |=> o_fault_irq)
    else $error("irq missing");

  // mode, converter over-current, high ovp, logic uv and input ov faults clear by their own pair only
  AST_MODE_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::MODE_FLAG_BIT] && i_wdata[fsr_pkg::MODE_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_MODE] |=> !flags.flag[fsr_pkg::FI_MODE])
    else $error("mode fault not cleared");

  AST_COC_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::COC_FLAG_BIT] && i_wdata[fsr_pkg::COC_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_CONV_OC] |=> !flags.flag[fsr_pkg::FI_CONV_OC])
    else $error("converter oc not cleared");

  AST_HOVP_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::HOVP_FLAG_BIT] && i_wdata[fsr_pkg::HOVP_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_HIGH_OVP] |=> !flags.flag[fsr_pkg::FI_HIGH_OVP])
    else $error("high ovp not cleared");

  AST_LUV_CLEAR: assert property (
    wr_sup && i_wdata[fsr_pkg::LUV_FLAG_BIT] && i_wdata[fsr_pkg::LUV_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_LOGIC_UV] |=> !flags.flag[fsr_pkg::FI_LOGIC_UV])
    else $error("logic uv not cleared");

  AST_OV_CLEAR: assert property (
    wr_sup && i_wdata[fsr_pkg::OV_FLAG_BIT] && i_wdata[fsr_pkg::OV_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_IN_OV] |=> !flags.flag[fsr_pkg::FI_IN_OV])
    else $error("input ov not cleared");

  // the remaining pairs clear by their own paired write as well
  AST_UV_CLEAR: assert property (
    wr_sup && i_wdata[fsr_pkg::UV_FLAG_BIT] && i_wdata[fsr_pkg::UV_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_IN_UV] |=> !flags.flag[fsr_pkg::FI_IN_UV])
    else $error("input uv not cleared");

  AST_OC_CLEAR: assert property (
    wr_sup && i_wdata[fsr_pkg::OC_FLAG_BIT] && i_wdata[fsr_pkg::OC_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_IN_OC] |=> !flags.flag[fsr_pkg::FI_IN_OC])
    else $error("input oc not cleared");

  AST_CAP_CLEAR: assert property (
    wr_sup && i_wdata[fsr_pkg::CAP_FLAG_BIT] && i_wdata[fsr_pkg::CAP_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_CAP] |=> !flags.flag[fsr_pkg::FI_CAP])
    else $error("capacitor fault not cleared");

  AST_THERM_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::THERM_FLAG_BIT] && i_wdata[fsr_pkg::THERM_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_THERMAL] |=> !flags.flag[fsr_pkg::FI_THERMAL])
    else $error("thermal fault not cleared");

  AST_CURR_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::CURR_FLAG_BIT] && i_wdata[fsr_pkg::CURR_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_CURRENT] |=> !flags.flag[fsr_pkg::FI_CURRENT])
    else $error("current resistor fault not cleared");

  AST_STR_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::STR_FLAG_BIT] && i_wdata[fsr_pkg::STR_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_STRING] |=> !flags.flag[fsr_pkg::FI_STRING])
    else $error("string resistor fault not cleared");

  AST_FREQ_CLEAR: assert property (
    wr_bst && i_wdata[fsr_pkg::FREQ_FLAG_BIT] && i_wdata[fsr_pkg::FREQ_FLAG_BIT-1]
    && !q.sync2[fsr_pkg::FI_FREQ] |=> !flags.flag[fsr_pkg::FI_FREQ])
    else $error("freq resistor fault not cleared");

  // pump flag sits just above its clear control
  AST_PUMP_READ: assert property (
    i_rd && addr_hit(i_addr, fsr_pkg::SUPPLY_ADDR)
    |=> o_rdata[fsr_pkg::PUMP_CLR_BIT+fsr_pkg::FLAG_OFS] == $past(flags.flag[fsr_pkg::FI_PUMP]))
    else $error("pump flag read mismatch");

  // supply bits above the pump pair are not built and read zero
  AST_SUP_UPPER_ZERO: assert property (
    i_rd && addr_hit(i_addr, fsr_pkg::SUPPLY_ADDR)
    |=> o_rdata[fsr_pkg::DATA_W-1:fsr_pkg::PUMP_CLR_BIT+fsr_pkg::PAIR_W] == '0)
    else $error("upper supply bits not zero");

  // clear controls read back as last written, checked across one idle cycle
  AST_SUP_CLR_READ: assert property (
    wr_sup ##1 !i_wr ##1 (i_rd && addr_hit(i_addr, fsr_pkg::SUPPLY_ADDR))
    |=> o_rdata[fsr_pkg::PUMP_CLR_BIT] == $past(i_wdata[fsr_pkg::PUMP_CLR_BIT], 3))
    else $error("pump clear control read mismatch");

  AST_BST_CLR_READ: assert property (
    wr_bst ##1 !i_wr ##1 (i_rd && addr_hit(i_addr, fsr_pkg::BOOST_ADDR))
    |=> o_rdata[fsr_pkg::THERM_FLAG_BIT-1] == $past(i_wdata[fsr_pkg::THERM_FLAG_BIT-1], 3))
    else $error("thermal clear control read mismatch");

  // with no latch pending the interrupt output falls
  AST_IRQ_IDLE: assert property (
    (flags.pin == '0) |=> !o_fault_irq)
    else $error("irq without pending latch");

  // a boost fault crosses the same two-flop synchroniser
  AST_THERM_LATENCY: assert property (
    i_fault_det[fsr_pkg::FI_THERMAL] ##1 i_fault_det[fsr_pkg::FI_THERMAL]
    |=> ##1 flags.flag[fsr_pkg::FI_THERMAL])
    else $error("thermal fault not latched");
endmodule

/* verilog/fsr_flag_bank.sv */
// Purpose: sticky fault flags and their interrupt pin latches
// Assumes: set is already synchronised, clr is a one-cycle request
// Notes:   set wins over clear in the same cycle
module fsr_flag_bank (
  input  wire logic  i_core_clk,
  input  wire logic  i_rst,
  fsr_flag_if.bank   bus
);
  typedef struct packed {
    logic [fsr_pkg::N_FLT-1:0] flag;
    logic [fsr_pkg::N_FLT-1:0] pin;
  } fsr_bank_s;

  fsr_bank_s q;
  fsr_bank_s d;

  // a fault arriving during its clearing write is kept, never lost
  always_comb
  begin
    d      = q;
    d.flag = (q.flag & ~bus.clr) | bus.set;
    d.pin  = ((q.pin & ~bus.clr) | bus.set) & fsr_pkg::PIN_EN;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign bus.flag = q.flag;
  assign bus.pin  = q.pin;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  AST_BANK_SET_WINS: assert property (
    (bus.set != '0) |=> ((bus.flag & $past(bus.set)) == $past(bus.set)))
    else $error("fault set lost");
  AST_BANK_HOLD: assert property (
    (bus.clr == '0) |=> ((bus.flag & $past(bus.flag)) == $past(bus.flag)))
    else $error("flag dropped without clear");
  AST_BANK_LOWOVP_PIN: assert property (
    bus.set[fsr_pkg::FI_LOW_OVP] |=> !bus.pin[fsr_pkg::FI_LOW_OVP])
    else $error("low ovp reached the pin");
endmodule

/* verilog/fsr_flag_if.sv */
// Purpose: carries set, clear and flag vectors to the flag bank
// Assumes: one bit per fault, combined index from fsr_pkg
// Notes:   ctrl drives set and clr, bank returns flag and pin
interface fsr_flag_if;
  logic [fsr_pkg::N_FLT-1:0] set;
  logic [fsr_pkg::N_FLT-1:0] clr;
  logic [fsr_pkg::N_FLT-1:0] flag;
  logic [fsr_pkg::N_FLT-1:0] pin;
  modport bank (input set, input clr, output flag, output pin);
  modport ctrl (output set, output clr, input flag, input pin);
endinterface

/* verilog/fsr_pkg.sv */
// Purpose: shared constants for the fault status register bank
// Assumes: 8-bit register address, 16-bit register data
// Notes:   each fault owns a pair of bits, flag above its clear control
package fsr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned N_SUP  = 6;
  localparam int unsigned N_BST  = 8;
  localparam int unsigned N_FLT  = 14;
  localparam int unsigned PAIR_W = 2;
  localparam int unsigned FLAG_OFS = 1;

  // register addresses on the bus
  localparam logic [7:0]  SUPPLY_ADDR = 8'h0E;
  localparam logic [7:0]  BOOST_ADDR  = 8'h10;
  localparam logic [15:0] REG_RESET   = 16'h0000;

  // combined fault index: supply pairs low, boost pairs high
  localparam int unsigned FI_IN_UV    = 0;
  localparam int unsigned FI_IN_OV    = 1;
  localparam int unsigned FI_LOGIC_UV = 2;
  localparam int unsigned FI_IN_OC    = 3;
  localparam int unsigned FI_CAP      = 4;
  localparam int unsigned FI_PUMP     = 5;
  localparam int unsigned FI_LOW_OVP  = 6;
  localparam int unsigned FI_HIGH_OVP = 7;
  localparam int unsigned FI_CONV_OC  = 8;
  localparam int unsigned FI_FREQ     = 9;
  localparam int unsigned FI_MODE     = 10;
  localparam int unsigned FI_STRING   = 11;
  localparam int unsigned FI_CURRENT  = 12;
  localparam int unsigned FI_THERMAL  = 13;

  // faults that also drive the interrupt pin; low boost ovp does not
  localparam logic [13:0] PIN_EN = 14'h3FBF;

  // field positions checked directly in the register image
  localparam int unsigned PUMP_CLR_BIT  = 10;
  localparam int unsigned CAP_FLAG_BIT  = 9;
  localparam int unsigned OC_FLAG_BIT   = 7;
  localparam int unsigned LUV_FLAG_BIT  = 5;
  localparam int unsigned OV_FLAG_BIT   = 3;
  localparam int unsigned UV_FLAG_BIT   = 1;
  localparam int unsigned THERM_FLAG_BIT = 15;
  localparam int unsigned CURR_FLAG_BIT = 13;
  localparam int unsigned STR_FLAG_BIT  = 11;
  localparam int unsigned MODE_FLAG_BIT = 9;
  localparam int unsigned FREQ_FLAG_BIT = 7;
  localparam int unsigned COC_FLAG_BIT  = 5;
  localparam int unsigned HOVP_FLAG_BIT = 3;
  localparam int unsigned LOVP_FLAG_BIT = 1;
endpackage
